// ===== include/can_filter_pkg.sv
// Constants shared by the CAN acceptance filter block
`default_nettype none
package can_filter_pkg;

    // ------------------------------------------------------------
    // Block dimensions
    // ------------------------------------------------------------
    localparam int          NUM_FILTERS       = 4;
    localparam logic [4:0]  FIRST_FILTER_NUM  = 5'h10;
    localparam int          ADDR_WIDTH        = 6;

    // ------------------------------------------------------------
    // Register byte offsets and block indices
    // ------------------------------------------------------------
    localparam logic [5:0]  CTRL_OFFSET       = 6'h00;
    localparam logic [5:0]  PATTERN_OFFSET    = 6'h10;
    localparam logic [5:0]  MASK_OFFSET       = 6'h20;
    localparam logic [1:0]  CTRL_BLOCK        = 2'h0;
    localparam logic [1:0]  PATTERN_BLOCK     = 2'h1;
    localparam logic [1:0]  MASK_BLOCK        = 2'h2;

    // ------------------------------------------------------------
    // Filter control byte fields (one byte per filter)
    // ------------------------------------------------------------
    localparam int          ENABLE_BIT        = 7;
    localparam int          MASK_SEL_LSB      = 5;
    localparam int          FIFO_SEL_LSB      = 0;

    // ------------------------------------------------------------
    // Identifier pattern and mask word fields
    // ------------------------------------------------------------
    localparam int          SID_MSB           = 31;
    localparam int          SID_LSB           = 21;
    localparam int          EXT_SEL_BIT       = 19;
    localparam int          EID_MSB           = 17;
    localparam int          EID_LSB           = 0;
    localparam logic [31:0] PATTERN_WR_MASK   = 32'hffeb_ffff;
    localparam logic [31:0] MASK_WR_MASK      = 32'hffe3_ffff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] PATTERN_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET        = 32'h0000_0000;

endpackage
`default_nettype wire

// ===== hdl/can_filter_match.sv
// Identifier compare for one acceptance filter
`timescale 1ns/1ps
`default_nettype none
module can_filter_match
    import can_filter_pkg::*;
(
    input  wire logic        enable_in,
    input  wire logic [31:0] pattern_in,
    input  wire logic [31:0] mask_in,
    input  wire logic        rx_extended_in,
    input  wire logic [10:0] rx_sid_in,
    input  wire logic [17:0] rx_eid_in,
    output logic             hit_out
);

    // ------------------------------------------------------------
    // Masked compare
    // ------------------------------------------------------------
    logic [10:0] sid_diff;
    logic [17:0] eid_diff;
    logic        format_ok;

    always_comb begin
        sid_diff  = (pattern_in[SID_MSB:SID_LSB] ^ rx_sid_in) & mask_in[SID_MSB:SID_LSB];
        eid_diff  = (pattern_in[EID_MSB:EID_LSB] ^ rx_eid_in) & mask_in[EID_MSB:EID_LSB];
        format_ok = (pattern_in[EXT_SEL_BIT] == rx_extended_in);
        // Extended bits only count for extended frames
        hit_out   = enable_in && format_ok && (sid_diff == 11'h000)
                    && (!rx_extended_in || (eid_diff == 18'h00000));
    end

endmodule
`default_nettype wire

// ===== hdl/can_filter_hit_select.sv
// Lowest-numbered hit wins among the filters
`timescale 1ns/1ps
`default_nettype none
module can_filter_hit_select
    import can_filter_pkg::*;
(
    input  wire logic [NUM_FILTERS-1:0]      hit_in,
    input  wire logic [NUM_FILTERS-1:0][4:0] fifo_sel_in,
    output logic                             any_hit_out,
    output logic [1:0]                       hit_index_out,
    output logic [4:0]                       hit_fifo_out
);

    // ------------------------------------------------------------
    // Priority encode
    // ------------------------------------------------------------
    always_comb begin
        any_hit_out   = 1'b0;
        hit_index_out = 2'h0;
        hit_fifo_out  = 5'h00;
        for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
            if (hit_in[i]) begin
                any_hit_out   = 1'b1;
                hit_index_out = i[1:0];
                hit_fifo_out  = fifo_sel_in[i];
            end
        end
    end

endmodule
`default_nettype wire

// ===== hdl/can_acceptance_filter_config.sv
// Acceptance filter settings, identifier patterns, masks and match path
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each filter has one enable bit; set joins matching, clear leaves it idle.
// - Two-bit selector picks acceptance mask 0 to 3 by its binary code.
// - Five-bit field names the receive FIFO 0 to 31 directly.
// - Mask and FIFO selects only change while that filter is disabled.
// - Four filters per control word, one byte each: enable, mask select, FIFO.
// - Standard identifier pattern sits in bits 31 to 21 of the pattern word.
// - Extended identifier pattern sits in bits 17 to 0 of the pattern word.
// - Bit 19 set matches extended frames only, clear matches standard only.
// - Pattern word writes only take effect while the filter is disabled.
// - Pattern bits 20 and 18 read as zero and ignore writes.
module can_acceptance_filter_config
    import can_filter_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic [ADDR_WIDTH-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out,
    input  wire logic                  rx_valid_in,
    input  wire logic                  rx_extended_in,
    input  wire logic [10:0]           rx_sid_in,
    input  wire logic [17:0]           rx_eid_in,
    output logic                       accept_out,
    output logic                       reject_out,
    output logic [4:0]                 accept_fifo_out,
    output logic [4:0]                 accept_filter_out,
    output logic [NUM_FILTERS-1:0]     filter_enable_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                   ctrl;
        logic [NUM_FILTERS-1:0][31:0]  pattern;
        logic [NUM_FILTERS-1:0][31:0]  mask;
        logic                          ack;
        logic [31:0]                   rdata;
        logic                          accept;
        logic                          reject;
        logic [4:0]                    fifo;
        logic [4:0]                    filter;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    // ------------------------------------------------------------
    // Per-filter field views and compare
    // ------------------------------------------------------------
    logic [NUM_FILTERS-1:0]       enable;
    logic [NUM_FILTERS-1:0][1:0]  mask_sel;
    logic [NUM_FILTERS-1:0][4:0]  fifo_sel;
    logic [NUM_FILTERS-1:0][31:0] chosen_mask;
    logic [NUM_FILTERS-1:0]       hit;
    logic                         any_hit;
    logic [1:0]                   hit_index;
    logic [4:0]                   hit_fifo;

    genvar g;
    generate
        for (g = 0; g < NUM_FILTERS; g++) begin : gen_filter
            // Byte g of the control word belongs to filter 16+g
            assign enable[g]      = st_ff.ctrl[8*g + ENABLE_BIT];
            assign mask_sel[g]    = st_ff.ctrl[8*g + MASK_SEL_LSB +: 2];
            assign fifo_sel[g]    = st_ff.ctrl[8*g + FIFO_SEL_LSB +: 5];
            assign chosen_mask[g] = st_ff.mask[mask_sel[g]];

            can_filter_match u_match (
                .enable_in      (enable[g]),
                .pattern_in     (st_ff.pattern[g]),
                .mask_in        (chosen_mask[g]),
                .rx_extended_in (rx_extended_in),
                .rx_sid_in      (rx_sid_in),
                .rx_eid_in      (rx_eid_in),
                .hit_out        (hit[g])
            );
        end
    endgenerate

    can_filter_hit_select u_select (
        .hit_in        (hit),
        .fifo_sel_in   (fifo_sel),
        .any_hit_out   (any_hit),
        .hit_index_out (hit_index),
        .hit_fifo_out  (hit_fifo)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [1:0]  reg_block;
    logic [1:0]  reg_slot;
    logic        bus_req;
    logic        bus_done;

    assign reg_block = avs_address_in[5:4];
    assign reg_slot  = avs_address_in[3:2];
    assign bus_req   = avs_read_in | avs_write_in;
    assign bus_done  = bus_req & st_ff.ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wr_bytes;
        logic [7:0]  ctrl_byte;
        logic [31:0] read_word;

        nxt_st    = st_ff;
        wr_bytes  = 32'h0000_0000;
        ctrl_byte = 8'h00;
        read_word = 32'h0000_0000;

        // One wait cycle on every access, answer on the second
        nxt_st.ack = bus_req & ~st_ff.ack;

        for (int k = 0; k < 4; k++) begin
            wr_bytes[8*k +: 8] = {8{avs_byteenable_in[k]}};
        end

        // Read mux, only implemented bits come back
        if (avs_address_in[1:0] == 2'h0) begin
            unique case (reg_block)
                CTRL_BLOCK: begin
                    if (reg_slot == 2'h0) begin
                        read_word = st_ff.ctrl;
                    end
                end
                PATTERN_BLOCK: begin
                    read_word = st_ff.pattern[reg_slot] & PATTERN_WR_MASK;
                end
                MASK_BLOCK: begin
                    read_word = st_ff.mask[reg_slot] & MASK_WR_MASK;
                end
                default: begin
                    read_word = 32'h0000_0000;
                end
            endcase
        end
        nxt_st.rdata = read_word;

        // Writes land on the edge where waitrequest is low
        if (avs_write_in && bus_done && avs_address_in[1:0] == 2'h0) begin
            unique case (reg_block)
                CTRL_BLOCK: begin
                    if (reg_slot == 2'h0) begin
                        for (int k = 0; k < NUM_FILTERS; k++) begin
                            ctrl_byte = avs_writedata_in[8*k +: 8];
                            if (avs_byteenable_in[k]) begin
                                if (!enable[k]) begin
                                    nxt_st.ctrl[8*k +: 8] = ctrl_byte;
                                end else begin
                                    // Enabled: only the enable itself may move
                                    nxt_st.ctrl[8*k + ENABLE_BIT] =
                                        ctrl_byte[ENABLE_BIT];
                                end
                            end
                        end
                    end
                end
                PATTERN_BLOCK: begin
                    if (!enable[reg_slot]) begin
                        nxt_st.pattern[reg_slot] =
                            (st_ff.pattern[reg_slot] & ~wr_bytes)
                            | (avs_writedata_in & wr_bytes & PATTERN_WR_MASK);
                    end
                end
                MASK_BLOCK: begin
                    nxt_st.mask[reg_slot] =
                        (st_ff.mask[reg_slot] & ~wr_bytes)
                        | (avs_writedata_in & wr_bytes & MASK_WR_MASK);
                end
                default: begin
                    nxt_st.ctrl = st_ff.ctrl;
                end
            endcase
        end

        // Receive path: one-cycle verdict per presented identifier
        nxt_st.accept = rx_valid_in & any_hit;
        nxt_st.reject = rx_valid_in & ~any_hit;
        if (rx_valid_in && any_hit) begin
            nxt_st.fifo   = hit_fifo;
            nxt_st.filter = FIRST_FILTER_NUM + {3'h0, hit_index};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff.ctrl    <= CTRL_RESET;
            st_ff.pattern <= {NUM_FILTERS{PATTERN_RESET}};
            st_ff.mask    <= {NUM_FILTERS{MASK_RESET}};
            st_ff.ack     <= 1'b0;
            st_ff.rdata   <= 32'h0000_0000;
            st_ff.accept  <= 1'b0;
            st_ff.reject  <= 1'b0;
            st_ff.fifo    <= 5'h00;
            st_ff.filter  <= 5'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest_out = bus_req & ~st_ff.ack;
    assign avs_readdata_out    = st_ff.rdata;
    assign accept_out          = st_ff.accept;
    assign reject_out          = st_ff.reject;
    assign accept_fifo_out     = st_ff.fifo;
    assign accept_filter_out   = st_ff.filter;
    assign filter_enable_out   = enable;

endmodule
`default_nettype wire

// ===== dv/can_acceptance_filter_config_props.sv
// Port checks for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
module can_filter_props
    import can_filter_pkg::*;
(
    input wire logic                  clk_in,
    input wire logic                  rst_b_in,
    input wire logic [ADDR_WIDTH-1:0] avs_address_in,
    input wire logic                  avs_read_in,
    input wire logic                  avs_write_in,
    input wire logic [31:0]           avs_writedata_in,
    input wire logic [3:0]            avs_byteenable_in,
    input wire logic [31:0]           avs_readdata_out,
    input wire logic                  avs_waitrequest_out,
    input wire logic                  rx_valid_in,
    input wire logic                  accept_out,
    input wire logic                  reject_out,
    input wire logic [4:0]            accept_fifo_out,
    input wire logic [4:0]            accept_filter_out,
    input wire logic [NUM_FILTERS-1:0] filter_enable_out
);
    // ------------------------------------------------------------
    // Bus completion and assertions
    // ------------------------------------------------------------
    logic rd_done;
    logic wr_done;
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    assign wr_done = avs_write_in && !avs_waitrequest_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_disabled_reject: assert property (
        rx_valid_in && filter_enable_out == '0 |=> reject_out)
        else $error("frame not refused with all filters off");
    a_one_answer: assert property (rx_valid_in |=> accept_out != reject_out)
        else $error("frame without exactly one answer");
    a_answer_cause: assert property ((accept_out || reject_out) |-> $past(rx_valid_in))
        else $error("answer without a frame");
    a_accept_enabled: assert property (accept_out |->
        (($past(filter_enable_out) >> accept_filter_out[1:0]) & 4'h1) == 4'h1)
        else $error("accept by a disabled filter");
    a_fifo_hold: assert property (!accept_out |->
        $stable(accept_fifo_out) && $stable(accept_filter_out))
        else $error("fifo number moved without accept");
    a_filter_range: assert property (accept_out |-> accept_filter_out[4:2] == 3'h4)
        else $error("winner number outside 16 to 19");
    a_enable_write: assert property (
        wr_done && avs_address_in == CTRL_OFFSET && avs_byteenable_in == 4'hf
        |=> filter_enable_out == {$past(avs_writedata_in[31]), $past(avs_writedata_in[23]),
        $past(avs_writedata_in[15]), $past(avs_writedata_in[7])})
        else $error("enable bits not taken from control write");
    a_ctrl_read: assert property (
        rd_done && avs_address_in == CTRL_OFFSET |-> {avs_readdata_out[31],
        avs_readdata_out[23], avs_readdata_out[15], avs_readdata_out[7]} == filter_enable_out)
        else $error("control read disagrees with enables");
    a_unimpl_zero: assert property (
        rd_done && avs_address_in[5:4] == 2'h1
        |-> avs_readdata_out[20] == 1'b0 && avs_readdata_out[18] == 1'b0)
        else $error("unimplemented pattern bits not zero");
endmodule
bind can_acceptance_filter_config can_filter_props u_props (.clk_in, .rst_b_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .rx_valid_in, .accept_out, .reject_out, .accept_fifo_out,
    .accept_filter_out, .filter_enable_out);
`default_nettype wire

// ===== dv/can_rx_path_model.sv
// Receive path model that presents identifiers to the filter
`timescale 1ns/1ps
`default_nettype none
module can_rx_path_model (
    input  wire logic        clk_in,
    output logic             rx_valid_out,
    output logic             rx_ext_out,
    output logic [10:0]      rx_sid_out,
    output logic [17:0]      rx_eid_out
);
    initial begin
        rx_valid_out = 1'b0;
        rx_ext_out = 1'b0;
        rx_sid_out = 11'h0;
        rx_eid_out = 18'h0;
    end
    // One cycle per frame, then stale lines show inverted values
    task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x);
        rx_valid_out <= 1'b1;
        rx_ext_out <= e;
        rx_sid_out <= s;
        rx_eid_out <= x;
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_ext_out <= ~e;
        rx_sid_out <= ~s;
        rx_eid_out <= ~x;
    endtask
endmodule
`default_nettype wire

// ===== dv/can_acceptance_filter_config_tb.sv
// Self-checking bench for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t got %h expected %h", $time, (a), (b)); end end
module can_acceptance_filter_config_tb
    import can_filter_pkg::*;
;
    logic clk_in = 1'b0, rst_b_in = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
    logic [5:0] addr = 6'h0;
    logic [31:0] wd = 32'h0, q, lf = 32'h55;
    logic [31:0] pat[4] = '{default: 32'h0}, msk[4];
    logic [7:0] ctl[4] = '{default: 8'h00};
    logic [3:0] be = 4'hf;
    logic [5:0] plain_addr[11] = '{6'h00, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24, 6'h28,
                                   6'h2c, 6'h30, 6'h02};
    wire logic [31:0] rdata;
    wire logic waitr, acc, rej, rx_v, rx_e;
    wire logic [4:0] afifo, afilt;
    wire logic [3:0] fen;
    wire logic [10:0] rx_s;
    wire logic [17:0] rx_x;
    int err_count = 0, checks_done = 0, cycles = 0;
    always #12.5 clk_in = ~clk_in;
    can_acceptance_filter_config dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
        .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitr),
        .rx_valid_in(rx_v), .rx_extended_in(rx_e), .rx_sid_in(rx_s), .rx_eid_in(rx_x),
        .accept_out(acc), .reject_out(rej), .accept_fifo_out(afifo),
        .accept_filter_out(afilt), .filter_enable_out(fen));
    can_rx_path_model rxm (.clk_in(clk_in), .rx_valid_out(rx_v), .rx_ext_out(rx_e),
        .rx_sid_out(rx_s), .rx_eid_out(rx_x));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    // Lowest enabled filter whose masked identifier agrees wins
    function automatic logic [7:0] predict(input logic e, input logic [10:0] s,
                                           input logic [17:0] x);
        logic [31:0] m;
        logic [31:0] p;
        for (int i = 0; i < 4; i++) begin
            m = msk[ctl[i][6:5]];
            p = pat[i];
            if (ctl[i][7] && p[19] == e && ((p[31:21] ^ s) & m[31:21]) == 11'h0
                && (!e || ((p[17:0] ^ x) & m[17:0]) == 18'h0)) return {1'b1, 2'(i), ctl[i][4:0]};
        end
        return 8'h0;
    endfunction
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        wr_req <= w;
        rd_req <= !w;
        addr <= a;
        wd <= d;
        do begin
            @(posedge clk_in);
        end while (waitr !== 1'b0);
        q = rdata;
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic frame(input logic e, input logic [10:0] s, input logic [17:0] x);
        logic [7:0] p;
        p = predict(e, s, x);
        rxm.send(e, s, x);
        @(posedge clk_in);
        `CHK({acc, rej}, {p[7], !p[7]})
        if (p[7]) `CHK({afilt, afifo}, {3'h4, p[6:5], p[4:0]})
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        int j;
        logic [3:0] lanes;
        msk = '{32'hffe3_ffff, 32'h0, 32'hffe0_0000, 32'h0003_ffff};
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        bus(1'b1, 6'h02, 32'hffff_ffff);
        bus(1'b1, 6'h30, rnd());
        foreach (plain_addr[i]) begin
            bus(1'b0, plain_addr[i], 32'h0);
            `CHK(q, 32'h0)
        end
        for (int k = 0; k < 4; k++) begin
            ctl[k] = 8'h0;
            pat[k] = 32'h0;
            r = rnd();
            frame(r[0], 11'h7ff, 18'h0);
            d = rnd();
            bus(1'b1, 6'h10 + 6'(4 * k), d);
            pat[k] = d & 32'hffeb_ffff;
            bus(1'b0, 6'h10 + 6'(4 * k), 32'h0);
            `CHK(q, pat[k])
            bus(1'b1, 6'h20 + 6'(4 * k), msk[k]);
        end
        // Corner control first: all enabled, every mask code, fifo 31 and 0
        for (int n = 0; n < 8; n++) begin
            d = (n == 0) ? 32'heac5_a09f : rnd();
            r = rnd();
            lanes = (n == 0) ? 4'hf : r[3:0];
            be <= lanes;
            bus(1'b1, 6'h00, d);
            be <= 4'hf;
            for (int k = 0; k < 4; k++) begin
                if (lanes[k]) begin
                    ctl[k] = ctl[k][7] ? {d[8*k+7], ctl[k][6:0]} : d[8*k +: 8];
                end
            end
            bus(1'b0, 6'h00, 32'h0);
            `CHK(q, {ctl[3], ctl[2], ctl[1], ctl[0]})
            `CHK(fen, {ctl[3][7], ctl[2][7], ctl[1][7], ctl[0][7]})
            j = n % 4;
            d = rnd();
            bus(1'b1, 6'h10 + 6'(4 * j), d);
            if (!ctl[j][7]) pat[j] = d & 32'hffeb_ffff;
            bus(1'b0, 6'h10 + 6'(4 * j), 32'h0);
            `CHK(q, pat[j])
            repeat (24) begin
                r = rnd();
                j = r[1:0];
                frame(r[2] ? pat[j][19] : r[3], pat[j][31:21] ^ (r[4] ? r[15:5] : 11'h0),
                      pat[j][17:0] ^ (r[16] ? r[31:14] : 18'h0));
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
